// *** hw/acfb_pkg.sv ***
// package: register offsets, field positions, reset values and carriers
// assumes: byte-wide register access through the device's i2c target
package acfb_pkg;

	localparam logic [7:0] ADDR_AC_CH2 = 8'h52;
	localparam logic [7:0] ADDR_AC_CH3 = 8'h53;
	localparam logic [7:0] ADDR_AC_CH4 = 8'h54;
	localparam logic [7:0] ADDR_CURVE = 8'h55;
	localparam logic [7:0] ADDR_MEM_CTRL = 8'h60;
	localparam logic [7:0] ADDR_MEM_DATA = 8'h61;
	localparam logic [7:0] ADDR_START_LO = 8'h62;
	localparam logic [7:0] ADDR_START_HI = 8'h63;
	localparam logic [7:0] ADDR_FW_REV = 8'h41;

	localparam int BIT_ACCESS_SEL = 7;
	localparam int BIT_CPU_HOLD = 6;
	localparam int BIT_PARITY_EN = 4;
	localparam int BIT_RAM_EN = 3;
	localparam int BIT_PARITY_SEL = 2;
	localparam int BIT_DIRECTION = 1;
	localparam int BIT_PTR_CLEAR = 0;
	localparam int AC_COUNT_W = 7;

	localparam logic [7:0] RESET_CURVE = 8'h00;
	localparam logic [7:0] RESET_MEM_CTRL = 8'h00;
	localparam logic [7:0] RESET_START = 8'h00;
	localparam logic [7:0] FW_REV_INVALID = 8'hFF;
	localparam logic [7:0] FW_REV_DEFAULT = 8'h01;

	localparam int AC_STEP_MW = 500;

	// one register access from the i2c target
	typedef struct packed {
		logic wr;
		logic rd;
		logic stop;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// one memory port access
	typedef struct packed {
		logic we;
		logic re;
		logic parity;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

endpackage : acfb_pkg

// *** hw/autoclass_foldback_sram_regs.sv ***
// register slice: auto-class power, alternative curve enables, program memory loading
// assumes: i2c target on link_clk hands byte accesses; memories and cpu on ref_clk
// Summary of operation
// RULE1 - channels 2 to 4 power bytes are read-only, bit 7 reads zero
// RULE2 - power count is peak average measurement; watts equal count times half watt
// RULE3 - upper nibble of curve register enables alternative operational curve per channel
// RULE4 - host sets operational curve enable before the channel power-on command
// RULE5 - lower nibble enables alternative inrush curve per channel
// RULE6 - host sets inrush enable before the channel power-on command
// RULE7 - memory port access works only while access select bit is one
// RULE8 - cpu hold bit holds processor reset, register contents untouched
// RULE9 - parity check runs only while parity enable bit is one
// RULE10 - host should enable parity whenever loaded code runs
// RULE11 - ram enable runs cpu from loaded memory and rom, else rom only
// RULE12 - host sets ram enable after loading memory
// RULE13 - parity select steers memory port to parity memory
// RULE14 - direction zero writes memory on data writes, one returns memory on reads
// RULE15 - unbroken byte stream to data port continues until stop
// RULE16 - pointer clear bit holds address pointer reset while one
// RULE17 - host pulses pointer clear low, high, low before memory access
// RULE18 - host defers other traffic until memory loading finishes
// RULE19 - host loads newest firmware at each power up
// RULE20 - start address from two byte registers, both reset zero
// RULE21 - failed compatibility check sets revision all ones, clears ram enable
// RULE22 - host waits fifty milliseconds after power on before loading
// RULE23 - host loads memory only at the lower target address
// RULE24 - pointer advances by one after every data port byte
// RULE25 - curve and control registers and power bytes are zero after reset
`timescale 1ns/1ns
module autoclass_foldback_sram_regs
	import acfb_pkg::*;
#(
	parameter int AC_CHANNELS = 3
)
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic link_clk,
	input wire acfb_pkg::reg_req_t link_req,
	output logic [7:0] link_rdata,
	input wire logic [AC_CHANNELS*7-1:0] ac_count_in,
	input wire logic ac_count_valid,
	input wire logic compat_done,
	input wire logic compat_fail,
	input wire logic [7:0] mem_rdata,
	input wire logic [7:0] parity_rdata,
	output acfb_pkg::mem_req_t mem_req,
	output logic [3:0] alt_operational_curve_enable,
	output logic [3:0] alt_inrush_curve_enable,
	output logic cpu_reset,
	output logic parity_check_enable,
	output logic ram_exec_enable,
	output logic [7:0] fw_revision
);
	import acfb_pkg::*;

	// ----------------------------------------------------------------
	// link side state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic tog;
		reg_req_t held;
		logic [7:0] rdata;
	} link_state_t;

	// ----------------------------------------------------------------
	// core side state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic [AC_CHANNELS-1:0][6:0] ac;
		logic [7:0] curve;
		logic [7:0] ctrl;
		logic [15:0] start;
		logic [15:0] ptr;
		logic streaming;
		logic [7:0] rdata;
		logic [7:0] fw;
		mem_req_t mem;
	} core_state_t;

	link_state_t l_q, l_d;
	core_state_t c_q, c_d;

	logic req_event;
	logic ack_event;
	logic [AC_CHANNELS-1:0][7:0] ac_byte;

	function automatic logic is_data_port(input reg_req_t r);
		is_data_port = (r.addr == ADDR_MEM_DATA);
	endfunction : is_data_port

	// data port open: access select set, pointer released
	function automatic logic port_open(input logic [7:0] ctrl);
		port_open = ctrl[BIT_ACCESS_SEL] && !ctrl[BIT_PTR_CLEAR];
	endfunction : port_open

	// memory byte as seen through the data port
	function automatic logic [7:0] port_byte(input logic [7:0] ctrl, input logic [7:0] prog, input logic [7:0] par);
		if (!ctrl[BIT_ACCESS_SEL] || !ctrl[BIT_DIRECTION])
			port_byte = 8'h00;
		else if (ctrl[BIT_PARITY_SEL])
			port_byte = par;
		else
			port_byte = prog;
	endfunction : port_byte

	// ----------------------------------------------------------------
	// register read-back
	// ----------------------------------------------------------------
	function automatic logic [7:0] readback(input core_state_t s, input logic [7:0] addr,
		input logic [AC_CHANNELS-1:0][7:0] ac, input logic [7:0] port);
		logic [7:0] v;
		v = 8'h00;
		case (addr)
			ADDR_AC_CH2: v = ac[0]; // RULE1
			ADDR_AC_CH3: v = ac[1]; // RULE1
			ADDR_AC_CH4: v = ac[2]; // RULE1
			ADDR_CURVE: v = s.curve;
			ADDR_MEM_CTRL: v = s.ctrl;
			ADDR_MEM_DATA: v = port; // RULE14
			ADDR_START_LO: v = s.start[7:0];
			ADDR_START_HI: v = s.start[15:8];
			ADDR_FW_REV: v = s.fw;
			default: v = 8'h00;
		endcase
		readback = v;
	endfunction : readback

	// ----------------------------------------------------------------
	// channel power bytes, top bit always zero
	// ----------------------------------------------------------------
	for (genvar g = 0; g < AC_CHANNELS; g++)
	begin : g_ac_byte
		assign ac_byte[g] = {1'b0, c_q.ac[g]}; // RULE1
	end

	// ----------------------------------------------------------------
	// crossings: request toggle into core, answer toggle back
	// ----------------------------------------------------------------
	toggle_sync i_req_sync (
		.clk(ref_clk),
		.reset(reset),
		.tog_in(l_q.tog),
		.event_out(req_event)
	);

	toggle_sync i_ack_sync (
		.clk(link_clk),
		.reset(reset),
		.tog_in(c_q.ack),
		.event_out(ack_event)
	);

	// ----------------------------------------------------------------
	// link domain: latch request, toggle event across
	// ----------------------------------------------------------------
	always_comb
	begin
		l_d = l_q;
		if (link_req.wr || link_req.rd || link_req.stop)
		begin
			l_d.held = link_req;
			l_d.tog = ~l_q.tog;
		end
		if (ack_event)
			l_d.rdata = c_q.rdata;
	end

	always_ff @(posedge link_clk or posedge reset)
	begin
		if (reset)
			l_q <= '0;
		else
			l_q <= l_d;
	end

	// ----------------------------------------------------------------
	// core domain: register file and memory port
	// ----------------------------------------------------------------
	always_comb
	begin
		logic ev;
		ev = req_event;
		c_d = c_q;
		c_d.mem.addr = c_q.ptr; // RULE24
		c_d.mem.we = 1'b0;
		c_d.mem.re = 1'b0;
		if (ac_count_valid)
			c_d.ac = ac_count_in; // RULE2
		if (c_q.ctrl[BIT_PTR_CLEAR])
		begin
			c_d.ptr = c_q.start; // RULE16 RULE20
			c_d.streaming = 1'b0;
		end
		if (ev)
		begin
			c_d.ack = ~c_q.ack;
			if (l_q.held.stop)
				c_d.streaming = 1'b0; // RULE15
			if (l_q.held.wr)
			begin
				case (l_q.held.addr)
					ADDR_CURVE: c_d.curve = l_q.held.wdata; // RULE3 RULE5
					ADDR_MEM_CTRL: c_d.ctrl = l_q.held.wdata; // RULE8
					ADDR_START_LO: c_d.start[7:0] = l_q.held.wdata; // RULE20
					ADDR_START_HI: c_d.start[15:8] = l_q.held.wdata; // RULE20
					default: ;
				endcase
			end
			if (is_data_port(l_q.held) && port_open(c_q.ctrl)
				&& (l_q.held.wr || l_q.held.rd)) // RULE7
			begin
				c_d.mem.addr = c_q.ptr;
				c_d.mem.parity = c_q.ctrl[BIT_PARITY_SEL]; // RULE13
				c_d.mem.wdata = l_q.held.wdata;
				c_d.mem.we = l_q.held.wr && !c_q.ctrl[BIT_DIRECTION]; // RULE14
				c_d.mem.re = l_q.held.rd && c_q.ctrl[BIT_DIRECTION]; // RULE14
				c_d.ptr = c_q.ptr + 16'h0001; // RULE24
				c_d.streaming = 1'b1; // RULE15
			end
			if (l_q.held.rd)
				c_d.rdata = readback(c_q, l_q.held.addr, ac_byte,
					port_byte(c_q.ctrl, mem_rdata, parity_rdata)); // RULE14
		end
		if (compat_done)
		begin
			if (compat_fail)
			begin
				c_d.fw = FW_REV_INVALID; // RULE21
				c_d.ctrl[BIT_RAM_EN] = 1'b0; // RULE21
			end
			else
				c_d.fw = FW_REV_DEFAULT;
		end
	end

	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			c_q <= '0; // RULE25
			c_q.curve <= RESET_CURVE; // RULE25
			c_q.ctrl <= RESET_MEM_CTRL; // RULE25
			c_q.start <= {RESET_START, RESET_START};
			c_q.fw <= FW_REV_DEFAULT;
		end
		else
			c_q <= c_d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign link_rdata = l_q.rdata;
	assign mem_req = c_q.mem;
	assign alt_operational_curve_enable = c_q.curve[7:4]; // RULE3
	assign alt_inrush_curve_enable = c_q.curve[3:0]; // RULE5
	assign cpu_reset = c_q.ctrl[BIT_CPU_HOLD]; // RULE8
	assign parity_check_enable = c_q.ctrl[BIT_PARITY_EN]; // RULE9
	assign ram_exec_enable = c_q.ctrl[BIT_RAM_EN]; // RULE11
	assign fw_revision = c_q.fw;

endmodule : autoclass_foldback_sram_regs

// ----------------------------------------------------------------
// toggle crossing: two flops, then edge of the toggle
// ----------------------------------------------------------------
module toggle_sync
(
	input wire logic clk,
	input wire logic reset,
	input wire logic tog_in,
	output logic event_out
);
	typedef struct packed {
		logic [2:0] taps;
		logic hit;
	} sync_state_t;

	sync_state_t s_q, s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.taps = {s_q.taps[1:0], tog_in};
		s_d.hit = s_q.taps[2] ^ s_q.taps[1];
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign event_out = s_q.hit;

endmodule : toggle_sync

// *** test/acfb_properties.sv ***
// checker: output timing relations of the register slice
// assumes: bound to the slice, watches the ref_clk domain only
`timescale 1ns/1ns
module acfb_properties
	import acfb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic compat_fail,
	input wire acfb_pkg::mem_req_t mem_req,
	input wire logic [3:0] alt_operational_curve_enable,
	input wire logic [3:0] alt_inrush_curve_enable,
	input wire logic cpu_reset,
	input wire logic parity_check_enable,
	input wire logic ram_exec_enable,
	input wire logic [7:0] fw_revision
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	write_pulse_a: assert property (mem_req.we |=> !mem_req.we) else $error("write strobe long");
	read_pulse_a: assert property (mem_req.re |=> !mem_req.re) else $error("read strobe long");
	one_direction_a: assert property (mem_req.we |-> !mem_req.re) else $error("read with write");
	fail_revision_a: assert property ($rose(compat_fail) |-> ##[1:8] fw_revision == FW_REV_INVALID)
		else $error("revision not set");
	fail_ram_off_a: assert property ($rose(compat_fail) |-> ##[1:8] !ram_exec_enable)
		else $error("ram enable kept");
	hold_keeps_curve_a: assert property ($changed(cpu_reset) |-> $stable(alt_inrush_curve_enable))
		else $error("hold touched curve");
	curve_alone_a: assert property ($changed(alt_operational_curve_enable) |-> $stable(cpu_reset))
		else $error("curve write moved hold");
	reset_zero_a: assert property (disable iff (1'b0) $fell(reset) |-> !cpu_reset && !ram_exec_enable
		&& !parity_check_enable && alt_operational_curve_enable == 4'h0) else $error("not clear after reset");
endmodule : acfb_properties
bind autoclass_foldback_sram_regs acfb_properties i_props (.ref_clk(ref_clk), .reset(reset),
	.compat_fail(compat_fail), .mem_req(mem_req), .alt_operational_curve_enable(alt_operational_curve_enable),
	.alt_inrush_curve_enable(alt_inrush_curve_enable), .cpu_reset(cpu_reset),
	.parity_check_enable(parity_check_enable), .ram_exec_enable(ram_exec_enable), .fw_revision(fw_revision));

// *** test/host_model.sv ***
// model: bus controller handing byte accesses to the slice
// assumes: link_clk runs free, one access at a time
`timescale 1ns/1ns
module host_model
	import acfb_pkg::*;
(
	input wire logic link_clk,
	output acfb_pkg::reg_req_t link_req
);
	initial link_req = '0;
	// one access, released fields inverted, then a quiet gap
	task automatic xfer(input logic w, input logic r, input logic s, input logic [7:0] a, input logic [7:0] d);
		@(posedge link_clk);
		#1 link_req = '{wr: w, rd: r, stop: s, addr: a, wdata: d};
		@(posedge link_clk);
		#1 link_req = '{wr: 1'b0, rd: 1'b0, stop: 1'b0, addr: ~a, wdata: ~d};
		repeat (40) @(posedge link_clk);
	endtask : xfer
endmodule : host_model

// *** test/tb_top.sv ***
// testbench: register sequences through the link side
// assumes: host_model drives requests, memory data modelled here
`timescale 1ns/1ns
module tb_top;
	import acfb_pkg::*;
	logic ref_clk = 0;
	logic link_clk = 0;
	logic reset = 1;
	logic [20:0] ac_count_in = '0;
	logic ac_count_valid = 0;
	logic compat_done = 0;
	logic compat_fail = 0;
	reg_req_t link_req;
	mem_req_t mem_req;
	logic [7:0] link_rdata, fw_revision;
	logic [3:0] alt_fb, alt_ir;
	logic cpu_reset, parity_check_enable, ram_exec_enable;
	int miscompares = 0;
	int compares = 0;
	logic [15:0] wr_addr[$];
	logic [7:0] wr_data[$];
	always #50 ref_clk = ~ref_clk;
	always #16 link_clk = ~link_clk;
	always @(posedge ref_clk) if (mem_req.we) wr_addr.push_back(mem_req.addr);
	always @(posedge ref_clk) if (mem_req.we) wr_data.push_back(mem_req.wdata);
	host_model i_host (.link_clk(link_clk), .link_req(link_req));
	autoclass_foldback_sram_regs i_dut (.ref_clk(ref_clk), .reset(reset), .link_clk(link_clk),
		.link_req(link_req), .link_rdata(link_rdata), .ac_count_in(ac_count_in), .ac_count_valid(ac_count_valid),
		.compat_done(compat_done), .compat_fail(compat_fail), .mem_rdata(mem_req.addr[7:0] ^ 8'h5A),
		.parity_rdata(~mem_req.addr[7:0]), .mem_req(mem_req), .alt_operational_curve_enable(alt_fb),
		.alt_inrush_curve_enable(alt_ir), .cpu_reset(cpu_reset), .parity_check_enable(parity_check_enable),
		.ram_exec_enable(ram_exec_enable), .fw_revision(fw_revision));
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_host.xfer(1'b1, 1'b0, 1'b0, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		i_host.xfer(1'b0, 1'b1, 1'b0, a, 8'h00);
		check(what, {8'h00, link_rdata}, {8'h00, exp});
	endtask : rd
	task automatic ctrl_pulse(input logic [7:0] base);
		wr(ADDR_MEM_CTRL, base);
		wr(ADDR_MEM_CTRL, base | 8'h01);
		wr(ADDR_MEM_CTRL, base);
	endtask : ctrl_pulse
	task automatic close_out();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out
	initial
	begin
		#1000000;
		miscompares++;
		close_out();
	end
	initial
	begin
		repeat (2) @(posedge ref_clk);
		#1 reset = 0;
		repeat (4) @(posedge link_clk);
		rd(ADDR_AC_CH2, 8'h00, "ac ch2 reset");
		rd(ADDR_CURVE, RESET_CURVE, "curve reset");
		rd(ADDR_MEM_CTRL, RESET_MEM_CTRL, "ctrl reset");
		rd(ADDR_START_HI, RESET_START, "start hi reset");
		@(posedge ref_clk);
		#1 ac_count_in = {7'h7F, 7'h33, 7'h01};
		ac_count_valid = 1;
		wr(ADDR_AC_CH3, 8'hFF);
		rd(ADDR_AC_CH2, 8'h01, "ac ch2");
		rd(ADDR_AC_CH3, 8'h33, "ac ch3 read only");
		rd(ADDR_AC_CH4, 8'h7F, "ac ch4 top bit");
		wr(ADDR_CURVE, 8'hA5);
		rd(ADDR_CURVE, 8'hA5, "curve");
		check("curve pins", {8'h00, alt_fb, alt_ir}, 16'h00A5);
		wr(ADDR_MEM_DATA, 8'h11);
		wr(ADDR_START_LO, 8'h34);
		wr(ADDR_START_HI, 8'h12);
		ctrl_pulse(8'hC0);
		check("cpu hold", {15'h0000, cpu_reset}, 16'h0001);
		for (int i = 0; i < 3; i++) wr(ADDR_MEM_DATA, 8'hD0 + 8'(i));
		i_host.xfer(1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
		check("write count", 16'(wr_addr.size()), 16'h0003);
		for (int i = 0; i < 3; i++) check("write addr", wr_addr[i], 16'h1234 + 16'(i));
		for (int i = 0; i < 3; i++) check("write data", {8'h00, wr_data[i]}, 16'h00D0 + 16'(i));
		check("curve kept", {8'h00, alt_fb, alt_ir}, 16'h00A5);
		ctrl_pulse(8'hC2);
		rd(ADDR_MEM_DATA, 8'h34 ^ 8'h5A, "mem read 0");
		rd(ADDR_MEM_DATA, 8'h35 ^ 8'h5A, "mem read 1");
		ctrl_pulse(8'hC6);
		rd(ADDR_MEM_DATA, ~8'h34, "parity read");
		wr(ADDR_MEM_CTRL, 8'h18);
		check("run flags", {13'h0000, cpu_reset, parity_check_enable, ram_exec_enable}, 16'h0003);
		@(posedge ref_clk);
		#1 compat_done = 1;
		compat_fail = 1;
		@(posedge ref_clk);
		#1 compat_done = 0;
		compat_fail = 0;
		repeat (8) @(posedge ref_clk);
		check("fail revision", {8'h00, fw_revision}, {8'h00, FW_REV_INVALID});
		rd(ADDR_MEM_CTRL, 8'h10, "ctrl after fail");
		close_out();
	end
endmodule : tb_top
